// File: isr_defs.vh
// register map and field layout of the input routing block
// included by the routing design files; definitions only
`ifndef ISR_DEFS_VH
`define ISR_DEFS_VH
`define ISR_OFF_MAP 4'h0
`define ISR_OFF_INV 4'h4
`define ISR_OFF_ACTMAP 4'h8
`define ISR_OFF_ACTINV 4'hC
`define ISR_OFF_INPUTS 5'h10
`define ISR_MAP_RST 16'h8888
`define ISR_INV_RST 16'h0000
`define ISR_FLD_HOME 0
`define ISR_FLD_LATCH1 4
`define ISR_FLD_LATCH2 8
`define ISR_FLD_LATCH3 12
`define ISR_SEL_NEVER 4'h8
`define ISR_SEL_ALWAYS 4'h9
`define ISR_SEL_INVBASE 4'hD
`define ISR_SEL_DIRBASE 4'h5
`endif

// File: isr_latch_decode.v
// one external latch selector decoder
// assumes terminals already synchronised
`timescale 1ns/10ps
`include "isr_defs.vh"
module isr_latch_decode (
  input wire [3:0] sel,
  input wire [7:0] term,
  output reg hit
);
  always @* begin
    hit = 1'b0;
    case (sel)
      4'h5: hit = term[5]; // see R04
      4'h6: hit = term[6]; // see R04
      4'h7: hit = term[7]; // see R04
      4'hD: hit = ~term[5]; // see R05
      4'hE: hit = ~term[6]; // see R05
      4'hF: hit = ~term[7]; // see R05
      // codes 0..4 and 8..C read inactive
      default: hit = 1'b0; // see R04
    endcase
  end
endmodule

// File: isr_input_routing.v
// input terminal routing with output inversion, Wishbone classic slave
// assumes one clock, synchronous active-low reset, single-cycle Wishbone master
// How it works
// R01: decel switch selector 0..7 picks terminal 0..7, active while ON.
// R02: decel switch selector 8 keeps the function always inactive.
// R03: decel switch selector 9 keeps the function always active.
// R04: latch 1 codes 0..4 inactive; 5..7 route terminals 5..7 direct.
// R05: latch 1 codes D..F route terminals 5..7 inverted.
// R06: latch 2 and 3 selectors decode like latch 1.
// R07: selection word is 16 bits, four 4-bit selector nibbles.
// R08: output inversion word has one digit per output, reset zero.
// R09: inversion digit 0 passes output, 1 inverts it.
// R10: written settings take effect only after the next reset; a reset held over a second edge restores the defaults instead.
// R11: terminals pass a two-flop synchroniser before routing.
`timescale 1ns/10ps
`include "isr_defs.vh"
module isr_input_routing #(
  parameter NUM_OUT = 4
) (
  input wire clk,
  input wire rstn,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [4:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  output wire wb_err_o,
  input wire [7:0] ioConnectorInputTerminal,
  input wire [NUM_OUT-1:0] outFunc,
  output reg [NUM_OUT-1:0] outTerminal,
  output reg homingDecelSwitchIn,
  output reg extLatchOneIn,
  output reg extLatchTwoIn,
  output reg extLatchThreeIn
);
  reg [15:0] mapSet_ff;
  reg [15:0] invSet_ff;
  reg [15:0] mapAct_ff;
  reg [15:0] invAct_ff;
  reg [7:0] syncA_ff;
  reg [7:0] syncB_ff;
  reg [31:0] nxt_rd;
  reg hitHome;
  wire hit1;
  wire hit2;
  wire hit3;
  wire [3:0] homeSel;
  wire [3:0] latch1Sel;
  wire [3:0] latch2Sel;
  wire [3:0] latch3Sel;
  wire busReq;
  wire takeReq;
  wire wrStb;
  wire selMap;
  wire selInv;
  wire selActMap;
  wire selActInv;
  wire selInputs;
  wire adrOk;
  integer i;

  // unmapped addresses still ack, reading zero; err kept idle
  assign wb_err_o = 1'b0;

  // a request is taken once; the ack that answers it is never stretched
  assign busReq = wb_cyc_i & wb_stb_i;
  assign takeReq = busReq & ~wb_ack_o;
  // writes land on the edge where the master sees ack, request still held
  assign wrStb = busReq & wb_we_i & wb_ack_o;

  // address decode
  assign selMap = (wb_adr_i == {1'b0, `ISR_OFF_MAP});
  assign selInv = (wb_adr_i == {1'b0, `ISR_OFF_INV});
  assign selActMap = (wb_adr_i == {1'b0, `ISR_OFF_ACTMAP});
  assign selActInv = (wb_adr_i == {1'b0, `ISR_OFF_ACTINV});
  assign selInputs = (wb_adr_i == `ISR_OFF_INPUTS);
  assign adrOk = selMap | selInv | selActMap | selActInv | selInputs;

  always @* begin
    nxt_rd = 32'h00000000;
    if (selMap) begin
      nxt_rd = {16'h0000, mapSet_ff};
    end else if (selInv) begin
      nxt_rd = {16'h0000, invSet_ff};
    end else if (selActMap) begin
      nxt_rd = {16'h0000, mapAct_ff};
    end else if (selActInv) begin
      nxt_rd = {16'h0000, invAct_ff};
    end else if (selInputs) begin
      nxt_rd = {24'h000000, syncB_ff};
    end
  end

  // read data stands only in the ack cycle, zero otherwise
  always @(posedge clk) begin
    if (!rstn) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= takeReq;
      if (takeReq && !wb_we_i && adrOk) begin
        wb_dat_o <= nxt_rd;
      end else begin
        wb_dat_o <= 32'h00000000;
      end
    end
  end

  // written settings; the active copies and the terminal word are read-only
  always @(posedge clk) begin
    if (!rstn) begin
      mapSet_ff <= `ISR_MAP_RST;
      invSet_ff <= `ISR_INV_RST; // see R08
    end else if (wrStb && selMap) begin
      if (wb_sel_i[0]) begin
        mapSet_ff[7:0] <= wb_dat_i[7:0]; // see R07
      end
      if (wb_sel_i[1]) begin
        mapSet_ff[15:8] <= wb_dat_i[15:8]; // see R07
      end
    end else if (wrStb && selInv) begin
      if (wb_sel_i[0]) begin
        invSet_ff[7:0] <= wb_dat_i[7:0];
      end
      if (wb_sel_i[1]) begin
        invSet_ff[15:8] <= wb_dat_i[15:8];
      end
    end
  end

  // the active copy follows the written value at every reset edge; since the
  // written registers reset too, a reset held over a second edge brings the
  // defaults back, so a setting carries over only a one-edge reset pulse
  always @(posedge clk) begin
    if (!rstn) begin
      mapAct_ff <= mapSet_ff; // see R10
      invAct_ff <= invSet_ff; // see R10
    end
  end

  // only the second stage reads the first, so no half-settled level leaks on
  always @(posedge clk) begin
    if (!rstn) begin
      syncA_ff <= 8'h00;
      syncB_ff <= 8'h00;
    end else begin
      syncA_ff <= ioConnectorInputTerminal; // see R11
      syncB_ff <= syncA_ff; // see R11
    end
  end

  // one selector nibble per function
  assign homeSel = mapAct_ff[`ISR_FLD_HOME +: 4];
  assign latch1Sel = mapAct_ff[`ISR_FLD_LATCH1 +: 4];
  assign latch2Sel = mapAct_ff[`ISR_FLD_LATCH2 +: 4];
  assign latch3Sel = mapAct_ff[`ISR_FLD_LATCH3 +: 4];

  // codes A..F are undefined for this function and read inactive
  always @* begin
    hitHome = 1'b0;
    case (homeSel)
      4'h0: hitHome = syncB_ff[0]; // see R01
      4'h1: hitHome = syncB_ff[1]; // see R01
      4'h2: hitHome = syncB_ff[2]; // see R01
      4'h3: hitHome = syncB_ff[3]; // see R01
      4'h4: hitHome = syncB_ff[4]; // see R01
      4'h5: hitHome = syncB_ff[5]; // see R01
      4'h6: hitHome = syncB_ff[6]; // see R01
      4'h7: hitHome = syncB_ff[7]; // see R01
      `ISR_SEL_NEVER: hitHome = 1'b0; // see R02
      `ISR_SEL_ALWAYS: hitHome = 1'b1; // see R03
      default: hitHome = 1'b0;
    endcase
  end

  // the three latch inputs use instances of one decoder module, so they cannot drift apart
  // see R04 see R05
  isr_latch_decode u_latch1 (
    .sel(latch1Sel),
    .term(syncB_ff),
    .hit(hit1)
  );
  // see R06
  isr_latch_decode u_latch2 (
    .sel(latch2Sel),
    .term(syncB_ff),
    .hit(hit2)
  );
  // see R06
  isr_latch_decode u_latch3 (
    .sel(latch3Sel),
    .term(syncB_ff),
    .hit(hit3)
  );

  // function levels leave from flops: terminal to function is three edges
  always @(posedge clk) begin
    if (!rstn) begin
      homingDecelSwitchIn <= 1'b0;
      extLatchOneIn <= 1'b0;
      extLatchTwoIn <= 1'b0;
      extLatchThreeIn <= 1'b0;
    end else begin
      homingDecelSwitchIn <= hitHome;
      extLatchOneIn <= hit1;
      extLatchTwoIn <= hit2;
      extLatchThreeIn <= hit3;
    end
  end

  // digit i sits at bit 4*i, so the word holds at most four outputs
  always @(posedge clk) begin
    if (!rstn) begin
      outTerminal <= {NUM_OUT{1'b0}};
    end else begin
      for (i = 0; i < NUM_OUT; i = i + 1) begin
        outTerminal[i] <= outFunc[i] ^ invAct_ff[4*i]; // see R09
      end
    end
  end
endmodule

// File: isr_input_routing_chk.sv
// checker for the input routing block
// sees only the top ports; bound after the module
`timescale 1ns/10ps
module isr_input_routing_chk #(parameter NUM_OUT = 4) (
  input wire clk,
  input wire rstn,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [4:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  input wire [31:0] wb_dat_o,
  input wire wb_ack_o,
  input wire wb_err_o,
  input wire [7:0] ioConnectorInputTerminal,
  input wire [NUM_OUT-1:0] outFunc,
  input wire [NUM_OUT-1:0] outTerminal,
  input wire homingDecelSwitchIn,
  input wire extLatchOneIn,
  input wire extLatchTwoIn,
  input wire extLatchThreeIn
);
  wire [3:0] fn = {extLatchThreeIn, extLatchTwoIn, extLatchOneIn, homingDecelSwitchIn};
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence req_s; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
  sequence up_s; $past(rstn) && $past(rstn, 2); endsequence
  ack_answer_a: assert property (req_s |=> wb_ack_o) else $error("request not acked");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  ack_cause_a: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  dat_quiet_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("stray data");
  err_low_a: assert property (!wb_err_o) else $error("error raised");
  rst_clear_a: assert property (disable iff (1'b0) !rstn |=> fn == 4'h0 && !wb_ack_o)
    else $error("reset left outputs set");
  route_stable_a: assert property (up_s ##0 $past(rstn, 3) && $past(rstn, 4) &&
    $past(ioConnectorInputTerminal, 3) == $past(ioConnectorInputTerminal, 4) |-> $stable(fn))
    else $error("function moved without terminal change");
  inv_track_a: assert property (up_s |-> (outTerminal ^ $past(outTerminal)) ==
    ($past(outFunc) ^ $past(outFunc, 2))) else $error("output inversion drifted");
endmodule
bind isr_input_routing isr_input_routing_chk #(.NUM_OUT(NUM_OUT)) isr_input_routing_chk_i (.*);

// File: isr_term_model.sv
// switch bank on the input terminals
// assumes the bench sets the wanted pattern
`timescale 1ns/10ps
module isr_term_model (
  input wire clk,
  input wire [7:0] want,
  output reg [7:0] term
);
  // edge aligned so the bench knows the latency exactly
  initial term = 8'h00;
  always @(posedge clk) begin
    term <= want;
  end
endmodule

// File: isr_input_routing_test.sv
// bench for the input routing block over classic Wishbone
// assumes the design files and the checker are compiled first
`timescale 1ns/10ps
module isr_input_routing_test;
  logic clk = 0, rstn = 0, cyc = 0, stb = 0, we = 0;
  logic [4:0] adr = 5'h00;
  logic [31:0] dat = 32'h0, wb_dat_o;
  logic [7:0] want = 8'hFF, term;
  logic [3:0] outFunc = 4'hF, outTerminal;
  logic wb_ack_o, home, e1, e2, e3;
  logic [15:0] q, pm = 16'h8888;
  int fails = 0, n_tests = 0;
  always #5 clk = ~clk;
  isr_term_model isr_term_model_i (.clk(clk), .want(want), .term(term));
  isr_input_routing isr_input_routing_i (.clk(clk), .rstn(rstn), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h3), .wb_dat_i(dat),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(), .ioConnectorInputTerminal(term),
    .outFunc(outFunc), .outTerminal(outTerminal), .homingDecelSwitchIn(home),
    .extLatchOneIn(e1), .extLatchTwoIn(e2), .extLatchThreeIn(e3));
  task results;
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task ck(input string n, input logic [15:0] e, input logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      fails++;
      $display("unexpected %s exp %h got %h", n, e, g);
    end
  endtask
  task wb(input logic w, input logic [4:0] a, input logic [15:0] d);
    int k;
    @(posedge clk);
    cyc <= 1; stb <= 1; we <= w; adr <= a; dat <= {16'h0000, d};
    for (k = 0; k < 50; k++) begin
      @(posedge clk);
      if (wb_ack_o === 1'b1) break;
    end
    if (k == 50) begin fails++; results(); end
    q = wb_dat_o[15:0];
    cyc <= 0; stb <= 0;
  endtask
  // one setting per reset pulse, since settings apply only at reset
  task cfg(input logic [15:0] m, v, input logic [7:0] t, input logic [3:0] f, o);
    wb(1, 5'h00, m); wb(1, 5'h04, v);
    wb(0, 5'h08, 0); ck("held map", pm, q);
    @(posedge clk); rstn <= 0; want <= t;
    @(posedge clk); rstn <= 1;
    repeat (5) @(posedge clk);
    pm = m;
    wb(0, 5'h08, 0); ck("active map", m, q);
    wb(0, 5'h10, 0); ck("terminals", {8'h00, t}, q);
    ck("functions", {12'h000, f}, {12'h000, e3, e2, e1, home});
    ck("outputs", {12'h000, o}, {12'h000, outTerminal});
    $display("test map %h done", m);
  endtask
  initial begin
    repeat (20) @(posedge clk);
    rstn <= 1;
    wb(0, 5'h00, 0); ck("map reset", 16'h8888, q);
    wb(0, 5'h04, 0); ck("inv reset", 16'h0000, q);
    wb(1, 5'h08, 16'h1234); wb(0, 5'h08, 0); ck("ro map", 16'h8888, q);
    wb(0, 5'h14, 0); ck("unmapped", 16'h0000, q);
    ck("forced off", 16'h0000, {12'h000, e3, e2, e1, home});
    ck("no inversion", 16'h000F, {12'h000, outTerminal});
    outFunc <= 4'h0;
    $display("test reset done");
    cfg(16'hD5E3, 16'h1010, 8'h28, 4'h7, 4'hA);
    cfg(16'h4F69, 16'h0101, 8'hC0, 4'h3, 4'h5);
    cfg(16'h7C08, 16'h0000, 8'hFF, 4'h8, 4'h0);
    cfg(16'h0007, 16'h1111, 8'h7F, 4'h0, 4'hF);
    results();
  end
endmodule
